/* File: logic/bus_route_defs.svh */
// Purpose: constants for the system bus decoder and arbiter
// Assumes: 32-bit addresses, four regions picked by the top two address bits
// Notes: segment match works on 4 kB granules
//
// Behaviour
// R1: Four fixed regions chosen only by address bits 31 and 30.
// R2: Eight programmable external segments, two SDRAM segments, one default segment.
// R3: After reboot the default segment serves boot ROM with nothing programmed.
// R4: Software programs every segment and descriptor before using the resource.
// R5: Overlapping segments resolve to the lower numbered segment.
// R6: Low memory remap starts cleared after reset.
// R7: Remap clear: region 0 aliases external ROM/RAM of region 2.
// R8: Remap set: regions 0 and 1 both reach SDRAM.
// R9: Local scratch SRAM never decodes inside the configuration region 3.
// R10: Swap clear: main display, DMA0, CPU, DMA1; peripheral DMA0, CPU, DMA1.
// R11: Swap set: DMA1 outranks CPU on both buses.
// R12: Priority swap starts cleared after reset.
// R13: Strict fixed priority; a busy high master may starve lower ones.
// R14: DMA masters use 4-word bursts kept inside one segment.
// R15: Unassigned or protected accesses flag a bus error and raise the interrupt; the code has no protection and flags only accesses decoding to no target.
// R16: Grant changes only at a transfer or burst boundary.
// R17: Display refresh master never takes part on the peripheral bus.
`ifndef BUS_ROUTE_DEFS_SVH
`define BUS_ROUTE_DEFS_SVH

`define REGION_LOW 2'h0
`define REGION_SDRAM 2'h1
`define REGION_EXT 2'h2
`define REGION_CONFIG 2'h3
`define GRANULE_LSB 12
`define SRAM_LSB 14
`define REMAP_RESET 1'h0
`define SWAP_RESET 1'h0
`define MAIN_NONE 4'h0
`define PERIPH_NONE 3'h0

`endif

/* File: logic/bus_route_pkg.sv */
// Purpose: types for the system bus decoder and arbiter
// Assumes: constants live in bus_route_defs.svh
// Notes: master index 0 display, 1 DMA0, 2 CPU, 3 DMA1
package bus_route_pkg;

  typedef enum logic [2:0] {
    tgt_none,
    tgt_ext,
    tgt_sdram,
    tgt_sram,
    tgt_config
  } target_t;

  typedef struct packed {
    logic enable;
    logic [19:0] base;
    logic [19:0] mask;
  } segment_t;

  typedef struct packed {
    logic valid;
    target_t target;
    logic [2:0] ext_seg;
    logic ext_default;
    logic sdram_seg;
    logic [31:0] addr;
  } decode_t;

  typedef struct packed {
    logic [3:0] main_grant;
    logic [2:0] periph_grant;
    decode_t dec;
    logic bus_error;
    logic bus_error_irq;
    logic remap;
    logic swap;
  } route_state_t;

endpackage : bus_route_pkg

/* File: logic/bus_route.sv */
// Purpose: main and peripheral bus arbitration plus main bus address decode
// Assumes: all inputs come from logic on ref_clk; masters hold req until served
// Notes: one registered cycle from request or address to grant or decode
`timescale 1ns/1ps
`include "bus_route_defs.svh"

module bus_route (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Mode bits
  input wire logic master_priority_swap,
  input wire logic low_memory_remap,
  // Main bus requests: 0 display, 1 DMA0, 2 CPU, 3 DMA1
  input wire logic [3:0] main_req,
  input wire logic main_xfer_end,
  // Peripheral bus requests: 0 DMA0, 1 CPU, 2 DMA1
  input wire logic [2:0] periph_req,
  input wire logic periph_xfer_end,
  // Main bus address from the owner
  input wire logic addr_valid,
  input wire logic [31:0] addr,
  // Segment setup
  input bus_route_pkg::segment_t [7:0] ext_segments,
  input bus_route_pkg::segment_t [1:0] sdram_segments,
  input wire logic sram_enable,
  input wire logic [31:0] sram_base,
  // Grants
  output logic [3:0] main_grant,
  output logic [2:0] periph_grant,
  // Decode result and errors
  output bus_route_pkg::decode_t dec,
  output logic bus_error,
  output logic bus_error_irq
);
  import bus_route_pkg::*;

  route_state_t cur;
  route_state_t nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Mode bits

  // Registered copies start at their reset values whatever the inputs do
  logic remap_now;
  logic swap_now;

  assign remap_now = cur.remap; // R6
  assign swap_now = cur.swap; // R12

  ////////////////////////////////////////////////////////////////////////////
  // Priority pick

  // Main bus: display and DMA0 always lead; swap orders CPU and DMA1
  function automatic logic [3:0] pick_main(input logic [3:0] req, input logic swap);
    logic [3:0] g;
    g = `MAIN_NONE;
    if (req[0]) begin
      g = 4'h1; // R10
    end else if (req[1]) begin
      g = 4'h2; // R10
    end else if (!swap && req[2]) begin
      g = 4'h4; // R10
    end else if (req[3]) begin
      g = 4'h8; // R11
    end else if (req[2]) begin
      g = 4'h4; // R11
    end
    return g;
  endfunction : pick_main

  // Peripheral bus holds no display master at all
  function automatic logic [2:0] pick_periph(input logic [2:0] req, input logic swap);
    logic [2:0] g;
    g = `PERIPH_NONE; // R17
    if (req[0]) begin
      g = 3'h1; // R10
    end else if (!swap && req[1]) begin
      g = 3'h2; // R10
    end else if (req[2]) begin
      g = 3'h4; // R11
    end else if (req[1]) begin
      g = 3'h2; // R11
    end
    return g;
  endfunction : pick_periph

  ////////////////////////////////////////////////////////////////////////////
  // Segment match

  logic [7:0] ext_hit;
  logic [1:0] sdram_hit;
  logic [31:0] eff_addr;

  // Alias region 0 onto the region it mirrors before matching
  always_comb begin
    eff_addr = addr;
    if (addr[31:30] == `REGION_LOW) begin
      eff_addr[31:30] = remap_now ? `REGION_SDRAM : `REGION_EXT; // R7 R8
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_ext
      assign ext_hit[gi] = ext_segments[gi].enable &&
        (((eff_addr[31:`GRANULE_LSB] ^ ext_segments[gi].base) &
          ext_segments[gi].mask) == 20'h0_0000); // R2
    end
    for (gi = 0; gi < 2; gi++) begin : g_sdram
      assign sdram_hit[gi] = sdram_segments[gi].enable &&
        (((eff_addr[31:`GRANULE_LSB] ^ sdram_segments[gi].base) &
          sdram_segments[gi].mask) == 20'h0_0000); // R2
    end
  endgenerate

  logic any_ext_enabled;
  logic [2:0] ext_first;
  logic sram_hit;

  always_comb begin
    any_ext_enabled = 1'b0;
    ext_first = 3'h0;
    for (int i = 0; i < 8; i++) begin
      any_ext_enabled = any_ext_enabled | ext_segments[i].enable;
    end
    // Walk downward so the lowest index wins an overlap
    for (int i = 7; i >= 0; i--) begin
      if (ext_hit[i]) begin
        ext_first = 3'(i); // R5
      end
    end
  end

  // Scratch SRAM refused if placed in the configuration region
  assign sram_hit = sram_enable && (sram_base[31:30] != `REGION_CONFIG) &&
    (addr[31:`SRAM_LSB] == sram_base[31:`SRAM_LSB]); // R9

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt = cur;
    nxt.bus_error = 1'b0;
    nxt.bus_error_irq = 1'b0;
    nxt.dec.valid = 1'b0;
    // Mode bits take effect one cycle after they are driven
    nxt.remap = low_memory_remap; // R6
    nxt.swap = master_priority_swap; // R12

    // Hold the owner until it ends its burst, even against higher requests
    if (cur.main_grant == `MAIN_NONE || main_xfer_end) begin
      nxt.main_grant = pick_main(main_req, swap_now); // R13 R16
    end
    if (cur.periph_grant == `PERIPH_NONE || periph_xfer_end) begin
      nxt.periph_grant = pick_periph(periph_req, swap_now); // R13 R16
    end

    if (addr_valid) begin
      nxt.dec.valid = 1'b1;
      nxt.dec.addr = addr;
      nxt.dec.target = tgt_none;
      nxt.dec.ext_seg = 3'h0;
      nxt.dec.ext_default = 1'b0;
      nxt.dec.sdram_seg = 1'b0;
      // Local SRAM overrides the region map where it is placed
      if (sram_hit) begin
        nxt.dec.target = tgt_sram;
      end else begin
        case (eff_addr[31:30]) // R1
          `REGION_SDRAM: begin
            if (sdram_hit[0]) begin
              nxt.dec.target = tgt_sdram; // R5
            end else if (sdram_hit[1]) begin
              nxt.dec.target = tgt_sdram;
              nxt.dec.sdram_seg = 1'b1;
            end
          end
          `REGION_EXT: begin
            if (|ext_hit) begin
              nxt.dec.target = tgt_ext;
              nxt.dec.ext_seg = ext_first; // R5
            end else if (!any_ext_enabled) begin
              // Nothing programmed yet: boot ROM through the default segment
              nxt.dec.target = tgt_ext;
              nxt.dec.ext_default = 1'b1; // R3
            end
          end
          `REGION_CONFIG: begin
            nxt.dec.target = tgt_config;
          end
          default: begin
            nxt.dec.target = tgt_none;
          end
        endcase
      end
      if (nxt.dec.target == tgt_none) begin
        nxt.bus_error = 1'b1; // R15
        nxt.bus_error_irq = 1'b1; // R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      cur.remap <= `REMAP_RESET; // R6
      cur.swap <= `SWAP_RESET; // R12
    end else begin
      cur <= nxt;
    end
  end

  assign main_grant = cur.main_grant;
  assign periph_grant = cur.periph_grant;
  assign dec = cur.dec;
  assign bus_error = cur.bus_error;
  assign bus_error_irq = cur.bus_error_irq;

endmodule : bus_route

/* File: dv/bus_route_asserts.sv */
// Purpose: bus_route port checker
// Assumes: one clock domain
// Notes: bound below
`timescale 1ns/1ps
module bus_route_asserts (
  // Clock and reset
  input logic ref_clk,
  input logic rst_n,
  // Requests and address
  input logic [3:0] main_req,
  input logic main_xfer_end,
  input logic periph_xfer_end,
  input logic addr_valid,
  input logic [31:0] addr,
  // Results
  input logic [3:0] main_grant,
  input logic [2:0] periph_grant,
  input bus_route_pkg::decode_t dec,
  input logic bus_error,
  input logic bus_error_irq
);
  import bus_route_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_main_onehot: assert property ($onehot0(main_grant)) else $error("main grant");
  a_per_onehot: assert property ($onehot0(periph_grant)) else $error("per grant");
  a_main_hold: assert property (main_grant != 0 && !main_xfer_end |=>
    $stable(main_grant)) else $error("main grant moved");
  a_per_hold: assert property (periph_grant != 0 && !periph_xfer_end |=>
    $stable(periph_grant)) else $error("per grant moved");
  a_dec_valid: assert property (dec.valid == $past(addr_valid)) else $error("dec late");
  a_err_irq: assert property (bus_error == bus_error_irq) else $error("irq");
  a_err_none: assert property (bus_error |-> dec.target == tgt_none) else $error("err");
  a_config_only: assert property (addr_valid && addr[31:30] == 2'h3 |=>
    dec.target == tgt_config) else $error("cfg");
  a_display_first: assert property (main_grant == 0 && main_req[0] |=>
    main_grant == 4'h1) else $error("display");
  c_dma1: cover property (main_grant == 4'h8);
  c_per_dma1: cover property (periph_grant == 3'h4);
  c_err: cover property (bus_error);
endmodule : bus_route_asserts

bind bus_route bus_route_asserts u_chk (.ref_clk, .rst_n, .main_req, .main_xfer_end,
  .periph_xfer_end, .addr_valid, .addr, .main_grant, .periph_grant, .dec, .bus_error,
  .bus_error_irq);

/* File: dv/bus_masters.sv */
// Purpose: masters that hold requests until served
// Assumes: load only while idle
// Notes: one 4-beat burst per master
`timescale 1ns/1ps
module bus_masters #(
  parameter int N = 4
) (
  // Clock and reset
  input logic ref_clk,
  input logic rst_n,
  // Bench side
  input logic load,
  input logic [N-1:0] want,
  // Bus side
  input logic [N-1:0] grant,
  output logic [N-1:0] req,
  output logic xfer_end
);
  logic [1:0] beats;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req <= '0;
      xfer_end <= 1'b0;
      beats <= 2'h0;
    end else begin
      xfer_end <= 1'b0;
      if (load) begin
        req <= req | want;
      end else if (grant != 0 && !xfer_end) begin
        beats <= beats + 2'h1;
        if (beats == 2'h3) begin
          xfer_end <= 1'b1;
          req <= req & ~grant;
        end
      end
    end
  end
endmodule : bus_masters

/* File: dv/bus_route_tb.sv */
// Purpose: self-checking bench for bus_route
// Assumes: masters from bus_masters
// Notes: decode cases follow the address map
`timescale 1ns/1ps
module bus_route_tb;
  import bus_route_pkg::*;
  logic ref_clk = 0, rst_n = 0, swap = 0, remap = 0, addr_valid = 0, sram_enable = 0;
  logic mload = 0, pload = 0, main_end, periph_end, bus_error, bus_error_irq;
  logic [3:0] mwant = 0, main_req, main_grant;
  logic [2:0] pwant = 0, periph_req, periph_grant;
  logic [31:0] addr = 0, sram_base = 0, x = 32'hcfd2;
  segment_t [7:0] ext = '0;
  segment_t [1:0] sdr = '0;
  decode_t dec;
  int mismatches = 0, samples_checked = 0;
  ////////////////////////////////////////
  bus_route uut (.ref_clk, .rst_n, .master_priority_swap(swap), .low_memory_remap(remap),
    .main_req, .main_xfer_end(main_end), .periph_req, .periph_xfer_end(periph_end),
    .addr_valid, .addr, .ext_segments(ext), .sdram_segments(sdr), .sram_enable,
    .sram_base, .main_grant, .periph_grant, .dec, .bus_error, .bus_error_irq);
  bus_masters #(.N(4)) mm (.ref_clk, .rst_n, .load(mload), .want(mwant),
    .grant(main_grant), .req(main_req), .xfer_end(main_end));
  bus_masters #(.N(3)) pm (.ref_clk, .rst_n, .load(pload), .want(pwant),
    .grant(periph_grant), .req(periph_req), .xfer_end(periph_end));
  initial forever #2 ref_clk = ~ref_clk;
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd
  // Priority list model; swap moves DMA1 above CPU
  function automatic int pick(int w, int s, int p);
    int o[4] = '{0, 1, 2, 3};
    if (s) begin
      o[2-p] = 3 - p;
      o[3-p] = 2 - p;
    end
    foreach (o[i]) if (w[o[i]]) return o[i];
    return 0;
  endfunction : pick
  task automatic chk(logic [31:0] g, logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic arb(int p, int w, int s);
    logic [3:0] g, last;
    int k;
    last = 0;
    while (w != 0) begin
      k = pick(w, s, p);
      g = last;
      for (int n = 0; n < 40 && g === last; n++) begin
        @(posedge ref_clk);
        #1 g = p ? {1'b0, periph_grant} : main_grant;
      end
      chk(g, 4'h1 << k);
      last = g;
      w[k] = 1'b0;
    end
  endtask : arb
  task automatic dchk(logic [31:0] a, target_t t, logic [3:0] s);
    @(posedge ref_clk);
    addr_valid <= 1;
    addr <= a;
    @(posedge ref_clk);
    addr_valid <= 0;
    #1 chk(dec.target, t);
    chk(dec.valid, 1'b1);
    chk(dec.addr, a);
    chk(bus_error, t == tgt_none);
    chk(bus_error_irq, t == tgt_none);
    if (t == tgt_ext) chk({dec.ext_default, dec.ext_seg}, s);
    if (t == tgt_sdram) chk(dec.sdram_seg, s);
  endtask : dchk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1;
    for (int i = 0; i < 24; i++) begin
      int mw, pw;
      mw = rnd() % 15 + 1;
      pw = rnd() % 7 + 1;
      @(posedge ref_clk);
      swap <= i[0];
      mload <= 1;
      mwant <= mw[3:0];
      pload <= 1;
      pwant <= pw[2:0];
      @(posedge ref_clk);
      mload <= 0;
      pload <= 0;
      fork
        arb(0, mw, i % 2);
        arb(1, pw, i % 2);
      join
      repeat (8) @(posedge ref_clk);
    end
    $display("arbitration done");
    dchk(32'h8000_1000, tgt_ext, 4'h8);
    dchk(32'h0000_1000, tgt_ext, 4'h8);
    dchk(32'h4000_0000, tgt_none, 4'h0);
    @(posedge ref_clk);
    sdr[0] <= '{1'b1, 20'h4_0000, 20'hf_0000};
    sdr[1] <= '{1'b1, 20'h4_0000, 20'he_0000};
    ext[0] <= '{1'b1, 20'h8_0000, 20'hf_ff00};
    ext[1] <= '{1'b1, 20'h8_0000, 20'hf_f000};
    remap <= 1;
    dchk(32'h0000_2000, tgt_sdram, 4'h0);
    dchk(32'h1000_0000, tgt_sdram, 4'h1);
    dchk(32'h8000_5000, tgt_ext, 4'h0);
    dchk(32'h8010_0000, tgt_ext, 4'h1);
    dchk(32'h9000_0000, tgt_none, 4'h0);
    dchk(32'hffff_4000, tgt_config, 4'h0);
    @(posedge ref_clk);
    sram_enable <= 1;
    sram_base <= 32'h8000_4000;
    dchk(32'h8000_4010, tgt_sram, 4'h0);
    @(posedge ref_clk);
    sram_base <= 32'hc000_0000;
    dchk(32'hc000_0010, tgt_config, 4'h0);
    $display("decode done");
    finish_test();
  end
endmodule : bus_route_tb
